// file: hw/pin_sync.sv
// Two-flop synchroniser for one pin
`timescale 1ns/10ps
module pin_sync (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // Pin and synchronised level
  input  wire logic pin_in,
  output logic      pin_out
);
  logic meta_q;

  // Reset level is the idle (high) pin level
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      meta_q  <= 1'b1;
      pin_out <= 1'b1;
    end else begin
      meta_q  <= pin_in;
      pin_out <= meta_q;
    end
  end
endmodule

// file: hw/sar_adc_parallel_control.sv
// Sampling, conversion, readout, nap and reset control of a SAR converter
`timescale 1ns/10ps
`include "sar_ctl_params.svh"

// Function
// [RULE_01] Busy is high for the whole conversion, low once it finishes.
// [RULE_02] Sampling starts on start rising with select low, or select falling with start high.
// [RULE_03] Back-to-back: start high before conversion end begins next sampling at that end.
// [RULE_04] Conversion starts on start falling with select low, or select falling with start low.
// [RULE_05] Busy rises promptly after the conversion-starting edge.
// [RULE_06] Select falling while busy and start high aborts; host avoids it for results.
// [RULE_07] An aborted conversion leaves the fixed code 3F80 as result.
// [RULE_08] Result drives the bus, msb on top, only while select and read are low.
// [RULE_09] Bus is released whenever select or read is high.
// [RULE_10] Byte select low gives the whole fourteen-bit result.
// [RULE_11] Byte select high folds low six bits to the top lines, zeros below.
// [RULE_12] Host uses back-to-back operation above 2.8 MSPS, allowed at any rate.
// [RULE_13] Each conversion finishes within the conversion time from its start edge.
// [RULE_14] In back-to-back the host keeps start high long enough before next start.
// [RULE_15] Nap enable low puts the device in nap after busy falls until next sampling.
// [RULE_16] Host lengthens the first acquisition after nap by 60 ns.
// [RULE_17] Nap lasts while nap enable low, busy low and no sampling started.
// [RULE_18] Powerdown/reset pin low acts asynchronously and enters the powerdown phase.
// [RULE_19] During the first reset window after the pin falls the output is 3F80.
// [RULE_20] Pin low beyond the powerdown threshold leaves reset and powers down.
// [RULE_21] First four conversions after power-up or reset are initialisation, invalid.
// [RULE_22] Host holds the pin low 45 to 6140 ns to reset, 7200 ns to power down.
// [RULE_23] Conversion aborts within 45 ns of reset; operation resumes when the pin rises.
// [RULE_24] Latest completed or abort result is held for reads until the next completes.
// [RULE_25] Host avoids reads and bus release during the quiet sampling period.
module sar_adc_parallel_control
  import sar_ctl_pkg::*;
(
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   sys_rst,
  // Host strobes, all asynchronous pins
  input  wire logic                   conversion_start_n,
  input  wire logic                   chip_select_n,
  input  wire logic                   read_strobe_n,
  input  wire logic                   byte_select,
  input  wire logic                   nap_enable_n,
  input  wire logic                   powerdown_reset_n,
  // Result of the analog core, sampled at conversion end
  input  wire logic [`RESULT_W-1:0]   core_result,
  // Status outputs
  output logic                        busy,
  output logic                        sampling,
  output logic                        nap_active,
  output logic                        powered_down,
  output logic                        in_reset,
  output logic                        result_invalid,
  // Three-state result bus as output and enable
  output logic [`RESULT_W-1:0]        result_bus_out,
  output logic                        result_bus_oe
);

  typedef struct packed {
    phase_t                  phase;
    logic [`CNT_W-1:0]       conv_cnt;
    logic [`CNT_W-1:0]       low_cnt;
    logic                    rst_seen;
    logic [`RESULT_W-1:0]    result;
    logic [2:0]              init_left;
    logic                    cs_prev;
    logic                    cv_prev;
    logic [`RESULT_W-1:0]    bus_data;
    logic                    bus_oe;
  } state_t;

  state_t s_q;
  state_t s_d;

  // Asynchronous pin synchronisers
  logic cv_s;
  logic cs_s;
  logic rd_s;
  logic by_s;
  logic nap_s;

  pin_sync u_sync_cv  (.sys_clk(sys_clk), .sys_rst(sys_rst), .pin_in(conversion_start_n), .pin_out(cv_s));
  pin_sync u_sync_cs  (.sys_clk(sys_clk), .sys_rst(sys_rst), .pin_in(chip_select_n),      .pin_out(cs_s));
  pin_sync u_sync_rd  (.sys_clk(sys_clk), .sys_rst(sys_rst), .pin_in(read_strobe_n),      .pin_out(rd_s));
  pin_sync u_sync_by  (.sys_clk(sys_clk), .sys_rst(sys_rst), .pin_in(~byte_select),       .pin_out(by_s));
  pin_sync u_sync_nap (.sys_clk(sys_clk), .sys_rst(sys_rst), .pin_in(nap_enable_n),       .pin_out(nap_s));

  // Reset pin: low level is caught asynchronously, release is synchronised
  logic pr_meta_q;
  logic pr_low_q;

  always_ff @(posedge sys_clk or negedge powerdown_reset_n) begin
    if (!powerdown_reset_n) begin // RULE_18
      pr_meta_q <= 1'b1;
      pr_low_q  <= 1'b1;
    end else begin
      pr_meta_q <= 1'b0;
      pr_low_q  <= pr_meta_q;
    end
  end

  // Edge events on synchronised strobes
  logic cs_fall;
  logic cv_fall;
  logic cv_rise;
  logic conv_end;
  logic sample_go;
  logic conv_go;
  logic abort_go;

  assign cs_fall = s_q.cs_prev && !cs_s;
  assign cv_fall = s_q.cv_prev && !cv_s;
  assign cv_rise = !s_q.cv_prev && cv_s;

  always_comb begin
    s_d       = s_q;
    conv_end  = 1'b0;
    sample_go = 1'b0;
    conv_go   = 1'b0;
    abort_go  = 1'b0;
    s_d.cs_prev = cs_s;
    s_d.cv_prev = cv_s;

    if (pr_low_q) begin
      // Reset window then powerdown while the pin stays low
      s_d.rst_seen  = 1'b1;
      s_d.conv_cnt  = '0;
      s_d.result    = `ABORT_CODE; // RULE_19 RULE_23
      s_d.init_left = `INIT_CONVERSIONS; // RULE_21
      if (s_q.low_cnt < `CNT_W'(`PWD_THRESH_CYCLES)) begin
        s_d.low_cnt = s_q.low_cnt + `CNT_W'(1);
        s_d.phase   = ST_IDLE;
      end else begin
        s_d.phase = ST_PWRDN; // RULE_20
      end
    end else begin
      s_d.low_cnt  = '0;
      s_d.rst_seen = 1'b0;
      if (s_q.phase == ST_PWRDN) begin
        s_d.phase = ST_IDLE; // RULE_23
      end
      unique case (s_q.phase)
        ST_IDLE, ST_NAP: begin
          // Sampling start; nap is left by it, by a select-edge conversion start or by nap enable going high
          if ((cv_rise && !cs_s) || (cs_fall && cv_s)) begin // RULE_02
            sample_go = 1'b1;
            s_d.phase = ST_SAMPLE;
          end else if (cs_fall && !cv_s) begin // RULE_04
            conv_go = 1'b1;
          end else if (!nap_s) begin
            s_d.phase = ST_NAP; // RULE_15 RULE_17
          end else begin
            s_d.phase = ST_IDLE;
          end
        end
        ST_SAMPLE: begin
          if ((cv_fall && !cs_s) || (cs_fall && !cv_s)) begin // RULE_04
            conv_go = 1'b1;
          end
        end
        ST_CONV: begin
          if (cs_fall && cv_s) begin // RULE_06
            abort_go     = 1'b1;
            s_d.result   = `ABORT_CODE; // RULE_07
            s_d.phase    = ST_IDLE;
            s_d.conv_cnt = '0;
          end else if (s_q.conv_cnt == `CNT_W'(`CONV_CYCLES - 1)) begin // RULE_13
            conv_end     = 1'b1;
            s_d.conv_cnt = '0;
            s_d.result   = core_result; // RULE_24
            if (s_q.init_left != 3'h0) begin
              s_d.init_left = s_q.init_left - 3'h1; // RULE_21
            end
            // Back-to-back: start already high with select low
            if (cv_s && !cs_s) begin // RULE_03
              s_d.phase = ST_SAMPLE;
            end else if (!nap_s) begin
              s_d.phase = ST_NAP; // RULE_15
            end else begin
              s_d.phase = ST_IDLE;
            end
          end else begin
            s_d.conv_cnt = s_q.conv_cnt + `CNT_W'(1);
          end
        end
        ST_PWRDN: begin
          s_d.phase = ST_IDLE;
        end
        default: begin
          s_d.phase = ST_IDLE;
        end
      endcase
      if (conv_go) begin
        s_d.phase    = ST_CONV; // RULE_05
        s_d.conv_cnt = '0;
      end
    end

    // Read path from the output latch
    s_d.bus_oe = !cs_s && !rd_s; // RULE_08 RULE_09
    if (!by_s) begin
      s_d.bus_data = {s_q.result[5:0], 8'h00}; // RULE_11
    end else begin
      s_d.bus_data = s_q.result; // RULE_10
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_q.phase     <= ST_IDLE;
      s_q.conv_cnt  <= '0;
      s_q.low_cnt   <= '0;
      s_q.rst_seen  <= 1'b0;
      s_q.result    <= `ABORT_CODE;
      s_q.init_left <= `INIT_CONVERSIONS;
      s_q.cs_prev   <= 1'b1;
      s_q.cv_prev   <= 1'b1;
      s_q.bus_data  <= '0;
      s_q.bus_oe    <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // Busy tracks the conversion phase directly
  assign busy           = (s_q.phase == ST_CONV); // RULE_01
  assign sampling       = (s_q.phase == ST_SAMPLE);
  assign nap_active     = (s_q.phase == ST_NAP);
  assign powered_down   = (s_q.phase == ST_PWRDN);
  assign in_reset       = s_q.rst_seen && (s_q.phase != ST_PWRDN);
  assign result_invalid = (s_q.init_left != 3'h0);
  assign result_bus_out = s_q.bus_data;
  assign result_bus_oe  = s_q.bus_oe;

  // Checks; an abort may cut busy short, so only the counter end or an abort may lower it
  AST_BUSY_LEN: assert property (@(posedge sys_clk) disable iff (sys_rst || pr_low_q) // RULE_01
    (busy && !conv_end && !abort_go) |=> busy)
    else $error("busy fell early");

  AST_BUSY_FALL: assert property (@(posedge sys_clk) disable iff (sys_rst || pr_low_q) // RULE_01 RULE_13
    conv_end |=> !busy)
    else $error("busy held after conversion end");

  AST_BUSY_BOUND: assert property (@(posedge sys_clk) disable iff (sys_rst || pr_low_q) // RULE_13
    $rose(busy) |-> ##[1:28] !busy || sampling)
    else $error("conversion too long");

  AST_CONV_COUNT: assert property (@(posedge sys_clk) disable iff (sys_rst || pr_low_q) // RULE_13
    busy |-> s_q.conv_cnt < `CNT_W'(`CONV_CYCLES))
    else $error("conversion counter overrun");

  AST_BUSY_PROMPT: assert property (@(posedge sys_clk) disable iff (sys_rst || pr_low_q) // RULE_05
    (sampling && cv_fall && !cs_s) |=> busy)
    else $error("busy not raised");

  AST_CONV_CS: assert property (@(posedge sys_clk) disable iff (sys_rst || pr_low_q) // RULE_04 RULE_05
    (sampling && cs_fall && !cv_s) |=> busy)
    else $error("select edge did not convert");

  AST_CONV_DIRECT: assert property (@(posedge sys_clk) disable iff (sys_rst || pr_low_q) // RULE_04
    ((s_q.phase == ST_IDLE || s_q.phase == ST_NAP) && cs_fall && !cv_s) |=> busy)
    else $error("select edge from idle did not convert");

  AST_SAMPLE_START: assert property (@(posedge sys_clk) disable iff (sys_rst || pr_low_q) // RULE_02
    sample_go |=> sampling)
    else $error("sampling not entered");

  AST_SAMPLE_EDGE: assert property (@(posedge sys_clk) disable iff (sys_rst || pr_low_q) // RULE_02
    (!busy && !sampling && !powered_down && ((cv_rise && !cs_s) || (cs_fall && cv_s))) |=> sampling)
    else $error("sampling edge missed");

  AST_ABORT: assert property (@(posedge sys_clk) disable iff (sys_rst || pr_low_q) // RULE_06 RULE_07
    abort_go |=> !busy && s_q.result == `ABORT_CODE)
    else $error("abort not handled");

  AST_ABORT_EDGE: assert property (@(posedge sys_clk) disable iff (sys_rst || pr_low_q) // RULE_06
    (busy && cs_fall && cv_s) |=> !busy)
    else $error("abort edge ignored");

  AST_B2B: assert property (@(posedge sys_clk) disable iff (sys_rst || pr_low_q) // RULE_03
    (conv_end && cv_s && !cs_s) |=> sampling)
    else $error("no back-to-back sample");

  AST_OE: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE_09
    (cs_s || rd_s) |=> !result_bus_oe)
    else $error("bus driven while deselected");

  AST_OE_ON: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE_08
    (!cs_s && !rd_s) |=> result_bus_oe)
    else $error("bus not driven on read");

  AST_FULL: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE_10
    by_s |=> result_bus_out == $past(s_q.result))
    else $error("full word mismatch");

  AST_FOLD: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE_11
    !by_s |=> result_bus_out[7:0] == 8'h00)
    else $error("fold low lines not zero");

  AST_FOLD_TOP: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE_11
    !by_s |=> result_bus_out[13:8] == $past(s_q.result[5:0]))
    else $error("fold top lines wrong");

  AST_RESULT_LATCH: assert property (@(posedge sys_clk) disable iff (sys_rst || pr_low_q) // RULE_24
    conv_end |=> s_q.result == $past(core_result))
    else $error("result not latched");

  AST_RESULT_HOLD: assert property (@(posedge sys_clk) disable iff (sys_rst || pr_low_q) // RULE_24
    (!conv_end && !abort_go) |=> $stable(s_q.result))
    else $error("result changed without event");

  AST_INIT_COUNT: assert property (@(posedge sys_clk) disable iff (sys_rst || pr_low_q) // RULE_21
    (conv_end && result_invalid) |=> s_q.init_left == $past(s_q.init_left) - 3'h1)
    else $error("initial conversion count wrong");

  AST_INIT_RELOAD: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE_21
    pr_low_q |=> result_invalid)
    else $error("initial conversions not restarted");

  AST_RESET_CODE: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE_19
    pr_low_q |=> s_q.result == `ABORT_CODE)
    else $error("reset code missing");

  AST_RST_WINDOW: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE_19
    (pr_low_q && s_q.low_cnt < `CNT_W'(`RST_WINDOW_CYCLES)) |=> in_reset)
    else $error("reset phase missing");

  AST_RST_IDLE: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE_18 RULE_23
    pr_low_q |=> !busy && !sampling)
    else $error("conversion survived reset");

  AST_PWRDN: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE_20
    (pr_low_q && s_q.low_cnt == `CNT_W'(`PWD_THRESH_CYCLES)) |=> powered_down && !in_reset)
    else $error("powerdown not entered");

  AST_RESUME: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE_23
    (powered_down && !pr_low_q) |=> !powered_down)
    else $error("powerdown not left");

  AST_NAP: assert property (@(posedge sys_clk) disable iff (sys_rst || pr_low_q) // RULE_15
    (conv_end && !nap_s && !(cv_s && !cs_s)) |=> nap_active)
    else $error("nap not entered");

  AST_NAP_HOLD: assert property (@(posedge sys_clk) disable iff (sys_rst || pr_low_q) // RULE_17
    (nap_active && !nap_s && !sample_go && !conv_go) |=> nap_active)
    else $error("nap left early");

  AST_NAP_EXIT: assert property (@(posedge sys_clk) disable iff (sys_rst || pr_low_q) // RULE_15 RULE_17
    (nap_active && sample_go) |=> sampling)
    else $error("nap not left by sampling");
endmodule

// file: hw/sar_ctl_params.svh
// Constants for the converter control block
`ifndef SAR_CTL_PARAMS_SVH
`define SAR_CTL_PARAMS_SVH
`define RESULT_W            14
`define ABORT_CODE          14'h3F80
`define CLK_PERIOD_NS       10
`define CONV_TIME_NS        273
`define CONV_CYCLES         (`CONV_TIME_NS / `CLK_PERIOD_NS)
`define RST_WINDOW_NS       6140
`define RST_WINDOW_CYCLES   (`RST_WINDOW_NS / `CLK_PERIOD_NS)
`define PWD_THRESH_NS       7200
`define PWD_THRESH_CYCLES   ((`PWD_THRESH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ABORT_LAT_NS        45
`define ABORT_LAT_CYCLES    (`ABORT_LAT_NS / `CLK_PERIOD_NS)
`define INIT_CONVERSIONS    3'h4
`define CNT_W               10
`endif

// file: hw/sar_ctl_pkg.sv
// Types for the converter control block
package sar_ctl_pkg;
  typedef enum logic [4:0] {
    ST_IDLE   = 5'b0_0001,
    ST_SAMPLE = 5'b0_0010,
    ST_CONV   = 5'b0_0100,
    ST_NAP    = 5'b0_1000,
    ST_PWRDN  = 5'b1_0000
  } phase_t;
endpackage

// file: testbench/host_model.sv
// Host model driving the converter strobes and read pins
`timescale 1ns/10ps
module host_model (
  // Clock
  input  wire logic sys_clk,
  // Pins toward the converter
  output logic      conversion_start_n,
  output logic      chip_select_n,
  output logic      read_strobe_n,
  output logic      byte_select,
  output logic      nap_enable_n,
  output logic      powerdown_reset_n
);
  initial begin
    conversion_start_n = 1'b1;
    chip_select_n      = 1'b1;
    read_strobe_n      = 1'b1;
    byte_select        = 1'b0;
    nap_enable_n       = 1'b1;
    powerdown_reset_n  = 1'b1;
  end
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Select low, start high opens sampling; start low after acq cycles converts
  task automatic acquire_convert(input int acq);
    @(posedge sys_clk);
    chip_select_n      <= 1'b0;
    conversion_start_n <= 1'b1;
    idle(acq);
    conversion_start_n <= 1'b0;
  endtask
  // Start back high during busy, well before the conversion ends
  task automatic rearm();
    @(posedge sys_clk);
    conversion_start_n <= 1'b1;
  endtask
  task automatic drive(input logic cs, input logic cv);
    @(posedge sys_clk);
    chip_select_n      <= cs;
    conversion_start_n <= cv;
  endtask
  // Reads only away from the start falling edge
  task automatic set_read(input logic rd, input logic bs);
    @(posedge sys_clk);
    read_strobe_n <= rd;
    byte_select   <= bs;
  endtask
  // Pulse widths chosen by the caller within the reset or powerdown ranges
  task automatic set_pins(input logic nap, input logic pwd);
    @(posedge sys_clk);
    nap_enable_n      <= nap;
    powerdown_reset_n <= pwd;
  endtask
endmodule

// file: testbench/test_sar_adc_parallel_control.sv
// Self-checking bench of the converter control block
`timescale 1ns/10ps
`include "sar_ctl_params.svh"
module test_sar_adc_parallel_control;
  logic                sys_clk;
  logic                sys_rst;
  logic [`RESULT_W-1:0] core_result;
  wire logic           cv_n;
  wire logic           cs_n;
  wire logic           rd_n;
  wire logic           bs;
  wire logic           nap_n;
  wire logic           pwd_n;
  logic                busy, sampling, nap_active, powered_down, in_reset, result_invalid;
  logic [`RESULT_W-1:0] result_bus_out;
  logic                result_bus_oe;
  int                  n_fail;
  int                  checks_done;
  logic [13:0]         vals [4] = '{14'h2A5C, 14'h15A3, 14'h3FFF, 14'h0081};

  always #5 sys_clk = ~sys_clk;

  host_model host (.sys_clk(sys_clk), .conversion_start_n(cv_n), .chip_select_n(cs_n),
    .read_strobe_n(rd_n), .byte_select(bs), .nap_enable_n(nap_n), .powerdown_reset_n(pwd_n));
  sar_adc_parallel_control dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .conversion_start_n(cv_n),
    .chip_select_n(cs_n), .read_strobe_n(rd_n), .byte_select(bs), .nap_enable_n(nap_n),
    .powerdown_reset_n(pwd_n), .core_result(core_result), .busy(busy), .sampling(sampling),
    .nap_active(nap_active), .powered_down(powered_down), .in_reset(in_reset),
    .result_invalid(result_invalid), .result_bus_out(result_bus_out), .result_bus_oe(result_bus_oe));

  task automatic test_done();
    if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // Bounded wait, sampled past the edge so register updates have landed
  task automatic wait_busy(input logic lvl, input int lim, output int n);
    n = 0;
    #1;
    while (busy !== lvl && n < lim) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
  endtask
  task automatic read_check(input logic b, input logic [13:0] exp);
    host.set_read(1'b0, b);
    host.idle(5);
    #1;
    check("bus_oe", result_bus_oe, 16'd1);
    check("bus_data", result_bus_out, exp);
    host.set_read(1'b1, b);
    host.idle(5);
    #1;
    check("bus_off", result_bus_oe, 16'd0);
  endtask
  task automatic conv(input logic [13:0] v, input logic b2b, input int acq);
    int n;
    @(posedge sys_clk);
    core_result <= v;
    host.acquire_convert(acq);
    wait_busy(1'b1, 8, n);
    check("busy_rise", 16'(n <= 4), 16'd1);
    check("busy_nap", nap_active, 16'd0);
    if (b2b) host.rearm();
    wait_busy(1'b0, 40, n);
    check("busy_span", 16'(n + b2b >= `CONV_CYCLES - 3 && n + b2b <= `CONV_CYCLES + 1), 16'd1);
    check("b2b_sample", sampling, b2b);
  endtask

  initial begin
    int n;
    sys_clk = 1'b0;
    sys_rst = 1'b1;
    core_result = '0;
    n_fail = 0;
    checks_done = 0;
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    check("invalid_rst", result_invalid, 16'd1);
    check("oe_rst", result_bus_oe, 16'd0);
    for (int i = 0; i < 4; i++) begin
      conv(vals[i], 1'(i % 2), 4);
      check("invalid", result_invalid, 16'(i < 3));
    end
    read_check(1'b0, vals[3]);
    read_check(1'b1, {vals[3][5:0], 8'h00});
    read_check(1'b0, vals[3]);
    // Nap after busy falls, held while idle
    host.set_pins(1'b0, 1'b1);
    conv(14'h0F0F, 1'b0, 4);
    host.idle(3);
    #1;
    check("nap_on", nap_active, 16'd1);
    host.idle(20);
    #1;
    check("nap_held", nap_active, 16'd1);
    conv(14'h3210, 1'b0, 10);
    check("nap_again", nap_active, 16'd1);
    host.set_pins(1'b1, 1'b1);
    read_check(1'b0, 14'h3210);
    // Abort by select falling with start high during busy
    @(posedge sys_clk);
    core_result <= 14'h1234;
    host.acquire_convert(4);
    wait_busy(1'b1, 8, n);
    host.drive(1'b1, 1'b1);
    host.idle(2);
    host.drive(1'b0, 1'b1);
    wait_busy(1'b0, 8, n);
    check("abort_busy", 16'(n <= 5), 16'd1);
    read_check(1'b0, `ABORT_CODE);
    // Short reset pulse during a conversion; select high first so its fall opens sampling
    host.drive(1'b1, 1'b1);
    host.acquire_convert(4);
    wait_busy(1'b1, 8, n);
    check("rst_busy", busy, 16'd1);
    host.set_pins(1'b1, 1'b0);
    host.idle(3);
    #1;
    check("rst_phase", in_reset, 16'd1);
    check("rst_abort", busy, 16'd0);
    read_check(1'b0, `ABORT_CODE);
    host.set_pins(1'b1, 1'b1);
    host.idle(4);
    #1;
    check("rst_left", in_reset, 16'd0);
    check("rst_invalid", result_invalid, 16'd1);
    // Long low level powers down past the threshold
    host.set_pins(1'b1, 1'b0);
    host.idle(`RST_WINDOW_CYCLES - 10);
    #1;
    check("pd_early", powered_down, 16'd0);
    host.idle(`PWD_THRESH_CYCLES - `RST_WINDOW_CYCLES + 20);
    #1;
    check("pd_on", powered_down, 16'd1);
    check("pd_rst", in_reset, 16'd0);
    host.set_pins(1'b1, 1'b1);
    host.idle(5);
    #1;
    check("pd_off", powered_down, 16'd0);
    test_done();
  end

  // Whole run needs under 2000 cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_fail++;
    test_done();
  end
endmodule
